// [nbu_pkg.sv]
// Shared constants and types for the nine-bit multiprocessor UART.
package nbu_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the Wishbone bus
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;  // serial_control_reg.
  localparam logic [3:0] ADDR_DATA = 4'h4;  // serial_buffer.

  // ---------------------------------------------------------------
  // Control register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_RX_FULL   = 0;
  localparam int BIT_TX_DONE   = 1;
  localparam int BIT_RX_NINTH  = 2;
  localparam int BIT_TX_NINTH  = 3;
  localparam int BIT_RX_EN     = 4;
  localparam int BIT_ADDR_FILT = 5;
  localparam int BIT_IRQ_EN    = 6;
  localparam int BIT_TX_BUSY   = 7;

  // ---------------------------------------------------------------
  // Character format and bit timing
  // ---------------------------------------------------------------
  localparam int         FRAME_BITS    = 11;     // Start, eight data, ninth, stop.
  localparam logic [3:0] TICK_LAST     = 4'hF;   // Sixteen ticks per bit.
  localparam logic [3:0] TICK_HALF     = 4'h7;   // Start bit checked at its middle.
  localparam logic [3:0] PAYLOAD_LAST  = 4'h8;   // Index of the ninth bit.
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} nbu_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} nbu_rx_e;

  typedef struct packed {
    logic irq_en;
    logic addr_filter_enable;
    logic rx_enable_bit;
    logic tx_ninth_bit;
  } nbu_ctrl_s;

endpackage

// [nbu_uart.sv]
// Nine-bit multiprocessor UART with a classic Wishbone register slave.
`timescale 1ns/1ps

// Contract
// RL1 - Character is start, eight data LSB first, ninth bit, stop: eleven bits.
// RL2 - Transmitted ninth bit equals the tx_ninth_bit control bit.
// RL3 - Received ninth bit goes to rx_ninth_bit; stop bit value ignored.
// RL4 - Writing serial_buffer starts a new character at once.
// RL5 - tx_done_flag sets when the stop-bit period begins.
// RL6 - Reception starts only while rx_enable_bit is 1.
// RL7 - Accept only if rx_full_flag is 0 and, when filtering, ninth bit is 1.
// RL8 - On accept store byte, store ninth bit, set rx_full_flag.
// RL9 - Interrupt request, when enabled, while either flag is set.
// RL10 - Master sends address characters with ninth bit 1, data with 0.
// RL11 - Addressed slave software clears addr_filter_enable; others leave it set.
// RL12 - Flags stay set until software writes zero; hardware never clears them.
// RL13 - Bits timed from one tick input; received bits sampled mid-bit.
module nbu_uart (
  input  wire logic        sys_clk,     // System clock, 20 MHz.
  input  wire logic        nrst,        // Asynchronous reset, active low.
  input  wire logic        baud_tick,   // Sixteen pulses per bit period, same clock.
  input  wire logic        rx_pin,      // Serial line in, asynchronous.
  output logic             tx_pin,      // Serial line out, idles high.
  output logic             irq,         // Serial interrupt request.
  input  wire logic        wb_cyc_i,    // Wishbone cycle.
  input  wire logic        wb_stb_i,    // Wishbone strobe.
  input  wire logic        wb_we_i,     // Wishbone write enable.
  input  wire logic [3:0]  wb_adr_i,    // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data.
  output logic [31:0]      wb_dat_o,    // Wishbone read data.
  output logic             wb_ack_o     // Wishbone acknowledge.
);

  // ---------------------------------------------------------------
  // Reset release and line synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_q, rst_n_q;
  logic rx_meta_q, rx_s_q;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // The idle-high line passes two flops before any logic looks at it.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_meta_q <= 1'b1;
      rx_s_q    <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_s_q    <= rx_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  nbu_pkg::nbu_ctrl_s ctrl_q, ctrl_d;
  logic       tx_done_q, tx_done_d, rx_full_q, rx_full_d, rx_ninth_q;
  logic [7:0] rx_buf_q;
  logic       ack_q;
  logic [31:0] rdat_q;

  // Bus decode: one request per handshake, answered on the next edge.
  wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = (wb_adr_i == nbu_pkg::ADDR_CTRL);
  wire hit_data = (wb_adr_i == nbu_pkg::ADDR_DATA);
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_data  = wr & hit_data;

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  nbu_pkg::nbu_tx_e tx_state_q;
  logic [3:0] tx_cnt_q, tx_bits_q;
  logic [8:0] tx_shift_q;
  logic       tx_line_q;

  wire tx_bit_end  = baud_tick & (tx_cnt_q == nbu_pkg::TICK_LAST);
  wire tx_done_set = (tx_state_q == nbu_pkg::TX_DATA) & tx_bit_end & ~wr_data
                   & (tx_bits_q == nbu_pkg::PAYLOAD_LAST);                  // RL5
  wire tx_line_d   = (tx_state_q == nbu_pkg::TX_START) ? 1'b0 :
                     (tx_state_q == nbu_pkg::TX_DATA)  ? tx_shift_q[0] : 1'b1; // RL1

  // A data write loads the byte and ninth bit and starts a start bit.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_state_q <= nbu_pkg::TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_bits_q  <= 4'h0;
      tx_shift_q <= 9'h1FF;
    end else if (wr_data) begin
      tx_state_q <= nbu_pkg::TX_START;                                     // RL4
      tx_cnt_q   <= 4'h0;
      tx_bits_q  <= 4'h0;
      tx_shift_q <= {ctrl_q.tx_ninth_bit, wb_dat_i[7:0]};                  // RL2
    end else if (baud_tick && tx_state_q != nbu_pkg::TX_IDLE) begin
      tx_cnt_q <= tx_cnt_q + 4'h1;                                         // RL13
      if (tx_bit_end) begin
        case (tx_state_q)
          nbu_pkg::TX_START: tx_state_q <= nbu_pkg::TX_DATA;
          nbu_pkg::TX_DATA: begin
            tx_shift_q <= {1'b1, tx_shift_q[8:1]};
            tx_bits_q  <= tx_bits_q + 4'h1;
            if (tx_bits_q == nbu_pkg::PAYLOAD_LAST) tx_state_q <= nbu_pkg::TX_STOP;
          end
          nbu_pkg::TX_STOP: tx_state_q <= nbu_pkg::TX_IDLE;
          default: tx_state_q <= nbu_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // The line output is registered so the pin comes from a flop.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) tx_line_q <= 1'b1;
    else          tx_line_q <= tx_line_d;
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  nbu_pkg::nbu_rx_e rx_state_q;
  logic [3:0] rx_cnt_q, rx_bits_q;
  logic [8:0] rx_shift_q;

  wire rx_mid      = baud_tick & (rx_cnt_q == nbu_pkg::TICK_LAST);
  wire rx_frame_end = (rx_state_q == nbu_pkg::RX_STOP) & rx_mid;          // RL3
  wire rx_accept   = rx_frame_end & ~rx_full_q & (~ctrl_q.addr_filter_enable | rx_shift_q[8]); // RL7

  // Falling edge starts a frame; each bit is sampled sixteen ticks apart.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_state_q <= nbu_pkg::RX_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_bits_q  <= 4'h0;
      rx_shift_q <= 9'h000;
    end else begin
      case (rx_state_q)
        nbu_pkg::RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          if (ctrl_q.rx_enable_bit && !rx_s_q) rx_state_q <= nbu_pkg::RX_START; // RL6
        end
        nbu_pkg::RX_START: if (baud_tick) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == nbu_pkg::TICK_HALF) begin                        // RL13
            rx_cnt_q   <= 4'h0;
            rx_bits_q  <= 4'h0;
            rx_state_q <= rx_s_q ? nbu_pkg::RX_IDLE : nbu_pkg::RX_DATA;
          end
        end
        nbu_pkg::RX_DATA: if (baud_tick) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_mid) begin
            rx_shift_q <= {rx_s_q, rx_shift_q[8:1]};                       // RL1
            rx_bits_q  <= rx_bits_q + 4'h1;
            if (rx_bits_q == nbu_pkg::PAYLOAD_LAST) rx_state_q <= nbu_pkg::RX_STOP;
          end
        end
        nbu_pkg::RX_STOP: if (baud_tick) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_mid) rx_state_q <= nbu_pkg::RX_IDLE;                      // RL3
        end
        default: rx_state_q <= nbu_pkg::RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control, flags and receive buffer
  // ---------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle.
  always_comb begin
    ctrl_d    = ctrl_q;
    tx_done_d = tx_done_q;
    rx_full_d = rx_full_q;
    if (wr_ctrl) begin
      ctrl_d.irq_en             = wb_dat_i[nbu_pkg::BIT_IRQ_EN];
      ctrl_d.addr_filter_enable = wb_dat_i[nbu_pkg::BIT_ADDR_FILT];        // RL11
      ctrl_d.rx_enable_bit      = wb_dat_i[nbu_pkg::BIT_RX_EN];
      ctrl_d.tx_ninth_bit       = wb_dat_i[nbu_pkg::BIT_TX_NINTH];
      tx_done_d = wb_dat_i[nbu_pkg::BIT_TX_DONE];                          // RL12
      rx_full_d = wb_dat_i[nbu_pkg::BIT_RX_FULL];                          // RL12
    end
    if (tx_done_set) tx_done_d = 1'b1;                                     // RL5
    if (rx_accept)   rx_full_d = 1'b1;                                     // RL8
  end

  // Flags, control bits and the received character.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q     <= '0;
      tx_done_q  <= 1'b0;
      rx_full_q  <= 1'b0;
      rx_ninth_q <= 1'b0;
      rx_buf_q   <= nbu_pkg::RESET_BYTE;
    end else begin
      ctrl_q    <= ctrl_d;
      tx_done_q <= tx_done_d;
      rx_full_q <= rx_full_d;
      if (rx_accept) begin
        rx_buf_q   <= rx_shift_q[7:0];                                     // RL8
        rx_ninth_q <= rx_shift_q[8];                                       // RL3
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and interrupt
  // ---------------------------------------------------------------
  wire [31:0] ctrl_rd = {24'h000000, (tx_state_q != nbu_pkg::TX_IDLE), ctrl_q.irq_en,
                         ctrl_q.addr_filter_enable, ctrl_q.rx_enable_bit, ctrl_q.tx_ninth_bit,
                         rx_ninth_q, tx_done_q, rx_full_q};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd : hit_data ? {24'h000000, rx_buf_q} : 32'h00000000;
  wire        irq_d   = ctrl_d.irq_en & (tx_done_d | rx_full_d);            // RL9

  // Ack one cycle after the request; unmapped reads return zero.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
      irq    <= 1'b0;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rd_mux : 32'h00000000;
      irq    <= irq_d;                                                     // RL9
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign tx_pin   = tx_line_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_frame_start;
    wr_data ##1 (tx_state_q == nbu_pkg::TX_START);
  endsequence

  property p_tx_start;
    @(posedge sys_clk) disable iff (!rst_n_q) s_frame_start |=> !tx_pin;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("Start bit not driven low."); // RL4

  property p_tx_ninth;
    @(posedge sys_clk) disable iff (!rst_n_q) wr_data |=> tx_shift_q[8] == $past(ctrl_q.tx_ninth_bit);
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("Ninth bit not loaded."); // RL2

  property p_tx_done_at_stop;
    @(posedge sys_clk) disable iff (!rst_n_q) tx_done_set |=> tx_done_q && tx_state_q == nbu_pkg::TX_STOP;
  endproperty
  a_tx_done_at_stop: assert property (p_tx_done_at_stop) else $error("Done not set at stop."); // RL5

  property p_rx_gate;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (rx_state_q == nbu_pkg::RX_IDLE && !ctrl_q.rx_enable_bit) |=> rx_state_q == nbu_pkg::RX_IDLE;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("Receiver left idle while off."); // RL6

  property p_rx_filter;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (rx_frame_end && (rx_full_q || (ctrl_q.addr_filter_enable && !rx_shift_q[8])))
        |=> $stable(rx_buf_q);
  endproperty
  a_rx_filter: assert property (p_rx_filter) else $error("Filtered character stored."); // RL7

  property p_rx_store;
    @(posedge sys_clk) disable iff (!rst_n_q)
      rx_accept |=> rx_full_q && rx_buf_q == $past(rx_shift_q[7:0]) && rx_ninth_q == $past(rx_shift_q[8]);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("Accepted character not stored."); // RL8

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n_q) (ctrl_q.irq_en && (tx_done_q || rx_full_q)) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing."); // RL9

  property p_flag_sticky;
    @(posedge sys_clk) disable iff (!rst_n_q) (rx_full_q && !wr_ctrl) |=> rx_full_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Receive flag cleared by hardware."); // RL12

  property p_ack_one;
    @(posedge sys_clk) disable iff (!rst_n_q) (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("Ack not a single cycle."); // Wishbone handshake.

endmodule

// [nbu_peer.sv]
// Serial peer node that sends characters into the block and captures its output.
`timescale 1ns/1ps
module nbu_peer (
  input  wire logic sys_clk,   // Bench clock.
  input  wire logic baud_tick, // Sixteen ticks per bit period.
  input  wire logic line_in,   // Line driven by the block.
  output logic      line_out   // Line into the block, idles high.
);
  logic [10:0] got_q;   // Last captured character, start bit at index 0.
  int          got_cnt; // Number of characters captured.

  initial line_out = 1'b1;
  initial got_cnt = 0;

  // Waits for the given number of bit-rate ticks.
  task automatic wait_ticks(input int n);
    repeat (n) begin
      do @(posedge sys_clk); while (baud_tick !== 1'b1);
    end
  endtask

  // Sends one character LSB first; the caller picks the ninth and stop values.
  task automatic send_char(input logic [7:0] d, input logic n9, input logic stop);
    logic [10:0] f;
    f = {stop, n9, d, 1'b0};
    for (int i = 0; i < nbu_pkg::FRAME_BITS; i++) begin
      line_out <= f[i];
      wait_ticks(16);
    end
    line_out <= 1'b1;
  endtask

  // Samples each outgoing bit at its middle; a start bit that is high by then is noise.
  always begin
    @(negedge line_in);
    wait_ticks(8);
    if (line_in === 1'b0) begin
      got_q[0] = 1'b0;
      for (int i = 1; i < nbu_pkg::FRAME_BITS; i++) begin
        wait_ticks(16);
        got_q[i] = line_in;
      end
      got_cnt++;
    end
  end
endmodule

// [tb_nine_bit_uart_multiproc.sv]
// Self-checking bench for the nine-bit multiprocessor UART.
`timescale 1ns/1ps
module tb_nine_bit_uart_multiproc;
  logic        sys_clk, nrst, baud_tick, rx_pin, tx_pin, irq;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [7:0]  b, last_b;
  logic        n9, last_n9, full;
  int          err_total, checked, n, k;
  integer      seed;
  // Receive cases: accept, stop value, ninth bit, control byte written first.
  logic [10:0] cases [6] = '{11'h100, 11'h610, 11'h351, 11'h230, 11'h730, 11'h410};

  nbu_uart i_dut (.sys_clk(sys_clk), .nrst(nrst), .baud_tick(baud_tick), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .irq(irq), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  nbu_peer i_peer (.sys_clk(sys_clk), .baud_tick(baud_tick), .line_in(tx_pin), .line_out(rx_pin));

  // ---------------------------------------------------------------
  // Clock, bit-rate tick and helpers
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // One tick every other cycle keeps frames short.
  initial baud_tick = 1'b0;
  always @(posedge sys_clk) begin
    baud_tick <= ~baud_tick;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Ends the run when a bounded wait ran out.
  task automatic must(input logic ok);
    if (!ok) begin
      $display("[ERR] wait expected done seen timeout");
      err_total++;
      give_verdict();
    end
  endtask

  // Expected line image of one character, start bit at index 0.
  function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic n9b);
    exp_frame = {1'b1, n9b, d, 1'b0};
  endfunction

  // Classic single Wishbone cycle; read data lands in q.
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    int w;
    w = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    must(w < 20);
    @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hD10BADAA;
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    err_total = 0;
    checked = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("tx_pin idle", 1, tx_pin);
    chk("irq idle", 0, irq);
    wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl reset", 0, q);
    wb(1'b1, 4'h8, 8'hFF);
    wb(1'b0, 4'h8, 8'h00);
    chk("unmapped read", 0, q);
    wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl after unmapped write", 0, q);
    // A write without the low byte select must leave control untouched.
    wb_sel_i <= 4'hE;
    wb(1'b1, nbu_pkg::ADDR_CTRL, 8'h50);
    wb_sel_i <= 4'hF;
    wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl after sel0 write", 0, q);
    // Transmit: corner bytes first, then random ones, each ninth bit taken from control.
    for (int t = 0; t < 4; t++) begin
      b = (t == 0) ? 8'hFF : (t == 1) ? 8'h00 : 8'($random(seed));
      n9 = (t == 1) ? 1'b1 : (t == 0) ? 1'b0 : 1'($random(seed));
      wb(1'b1, nbu_pkg::ADDR_CTRL, {4'h4, n9, 3'h0});
      n = i_peer.got_cnt;
      wb(1'b1, nbu_pkg::ADDR_DATA, b);
      k = 0;
      do begin
        wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
        k++;
      end while (q[nbu_pkg::BIT_TX_DONE] !== 1'b1 && k < 400);
      must(k < 400);
      chk("stop not yet sampled at tx done", n, i_peer.got_cnt);
      chk("irq on tx done", 1, irq);
      k = 0;
      while (i_peer.got_cnt == n && k < 400) begin
        @(posedge sys_clk);
        k++;
      end
      must(k < 400);
      chk("tx frame", exp_frame(b, n9), i_peer.got_q);
      repeat (40) @(posedge sys_clk);
      wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
      chk("tx_done held", 1, q[nbu_pkg::BIT_TX_DONE]);
      wb(1'b1, nbu_pkg::ADDR_CTRL, 8'h00);
      chk("irq after clear", 0, irq);
    end
    // Receive: disabled, plain, full, filtered data, address, addressed data with a bad stop.
    last_b = nbu_pkg::RESET_BYTE;
    last_n9 = 1'b0;
    for (int c = 0; c < 6; c++) begin
      b = 8'($random(seed));
      wb(1'b1, nbu_pkg::ADDR_CTRL, cases[c][7:0]);
      i_peer.send_char(b, cases[c][8], cases[c][9]);
      repeat (40) @(posedge sys_clk);
      if (cases[c][10]) begin
        last_b = b;
        last_n9 = cases[c][8];
      end
      full = cases[c][10] | cases[c][0];
      wb(1'b0, nbu_pkg::ADDR_CTRL, 8'h00);
      chk("rx_full", full, q[nbu_pkg::BIT_RX_FULL]);
      chk("rx_ninth", last_n9, q[nbu_pkg::BIT_RX_NINTH]);
      chk("irq on rx", full & cases[c][6], irq);
      wb(1'b0, nbu_pkg::ADDR_DATA, 8'h00);
      chk("rx byte", last_b, q);
    end
    give_verdict();
  end
endmodule
